// ### include/tdsr_consts.vh
// Register indices, field positions and constants of the tile debug state register bank.
`ifndef TDSR_CONSTS_VH
`define TDSR_CONSTS_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define TDSR_IDX_TILE_WIRE_OSC   8'h08
`define TDSR_IDX_PCELL_OSC       8'h09
`define TDSR_IDX_PWIRE_OSC       8'h0A
`define TDSR_IDX_MEM_SIZE        8'h0C
`define TDSR_IDX_CAP_STATUS      8'h10
`define TDSR_IDX_CAP_PC          8'h11
`define TDSR_IDX_CAP_SP          8'h12
`define TDSR_IDX_THREAD_SEL      8'h13
`define TDSR_IDX_REG_SEL         8'h14
`define TDSR_IDX_CAUSE           8'h15
`define TDSR_IDX_PAYLOAD         8'h16
`define TDSR_IDX_HOLD_MASK       8'h18
`define TDSR_IDX_XCHG_BASE       8'h20
`define TDSR_IDX_XCHG_LAST       8'h27

// ************************************************************
// Field layouts
// ************************************************************
`define TDSR_OSC_W               16
`define TDSR_STATUS_W            11
`define TDSR_STATUS_DRW_MASK     11'h6DF
`define TDSR_ISSUE_MODE_BIT      8
`define TDSR_THREAD_W            8
`define TDSR_REGNUM_W            5
`define TDSR_CAUSE_CODE_W        3
`define TDSR_BPIDX_W             2
`define TDSR_CAUSE_MASK          32'h0003FF07
`define TDSR_MEM_SIZE_MASK       32'hFFFFFFFC
`define TDSR_ADDR_IDX_HI         9
`define TDSR_ADDR_IDX_LO         2
`define TDSR_CAUSE_THREAD_LSB    8
`define TDSR_CAUSE_BP_LSB        16

// ************************************************************
// Cause codes and defaults
// ************************************************************
`define TDSR_CAUSE_HOST          3'h1
`define TDSR_CAUSE_DEBUG_CALL_INSTR         3'h2
`define TDSR_CAUSE_IBREAK        3'h3
`define TDSR_CAUSE_DWATCH        3'h4
`define TDSR_CAUSE_RWATCH        3'h5
`define TDSR_MEM_SIZE_BYTES      32'h00080000
`define TDSR_HTRANS_NONSEQ       2'h2
`define TDSR_HSIZE_WORD          3'h2
`define TDSR_ZERO32              32'h00000000

`endif

// ### logic/tdsr_regs.v
// Tile debug state register bank with an AHB-Lite slave port.
//
// Notes on behaviour
// - Tile wire oscillator count reads in bits 15:0 at index 0x08, read only.
// - Peripheral cell oscillator count reads in bits 15:0 at index 0x09.
// - Peripheral wire oscillator count reads in bits 15:0 at index 0x0A.
// - Oscillator counts keep their value through system reset.
// - Memory size in bytes reads at index 0x0C, bits 31:2, low bits zero.
// - Debug entry captures the saved status into index 0x10.
// - Status bits 0..4: events, interrupts, event setup, handler, kernel mode.
// - Status bit 7 fast issue, bit 6 paused waiting.
// - Status bit 8 read-only issue mode, bit 9 entry mode, bit 10 address space.
// - Debug entry captures the full 32-bit saved program counter at 0x11.
// - Debug entry captures the full 32-bit saved stack pointer at 0x12.
// - Eight-bit thread number at 0x13 selects the state-read thread.
// - Five-bit register number at 0x14 selects the state-read register.
// - Three-bit cause at 0x15: host, call, ibreak, dwatch, rwatch codes 1..5.
// - Breakpoint index in bits 17:16, zero for host and call, lowest wins.
// - Causing thread in bits 15:8, zero when the host caused entry.
// - Index 0x16 loads the watch address or resource identifier.
// - Eight-bit hold mask at 0x18 keeps marked threads stopped after return.
// - Eight scratch words at 0x20..0x27 shared with the external debugger.
module tdsr_regs (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  // AHB-Lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  // Ring oscillator counters
  input  wire [15:0] tile_wire_osc_count_i,
  input  wire [15:0] periph_cell_osc_count_i,
  input  wire [15:0] periph_wire_osc_count_i,
  // Processor core
  input  wire        debug_mode_i,
  input  wire        dbg_entry_i,
  input  wire [2:0]  dbg_entry_cause_i,
  input  wire [7:0]  dbg_entry_thread_i,
  input  wire [3:0]  dbg_entry_bp_hits_i,
  input  wire [31:0] dbg_entry_payload_i,
  input  wire [10:0] saved_status_register_i,
  input  wire [31:0] saved_program_counter_i,
  input  wire [31:0] saved_stack_pointer_i,
  input  wire        issue_mode_bit_i,
  // Exchange words from the configuration space
  input  wire        cfg_xchg_we_i,
  input  wire [2:0]  cfg_xchg_idx_i,
  input  wire [31:0] cfg_xchg_wdata_i,
  output reg  [31:0] cfg_xchg_rdata_o,
  // Operands for the state-read instruction and run control
  output reg  [7:0]  state_read_thread_o,
  output reg  [4:0]  state_read_register_o,
  output reg  [7:0]  thread_hold_mask_o
);

`include "tdsr_consts.vh"

  // ************************************************************
  // Functions
  // ************************************************************

  // Lowest set breakpoint bit wins when several fire together.
  function [1:0] lowest_hit;
    input [3:0] hits;
    begin
      if (hits[0]) begin
        lowest_hit = 2'h0;
      end else if (hits[1]) begin
        lowest_hit = 2'h1;
      end else if (hits[2]) begin
        lowest_hit = 2'h2;
      end else begin
        lowest_hit = hits[3] ? 2'h3 : 2'h0;
      end
    end
  endfunction

  // Scratch words occupy one run of eight consecutive indices.
  function in_xchg;
    input [7:0] idx;
    begin
      in_xchg = (idx >= `TDSR_IDX_XCHG_BASE) && (idx <= `TDSR_IDX_XCHG_LAST);
    end
  endfunction

  // Only the two watch causes bring an address or identifier worth keeping.
  function is_watch;
    input [2:0] cause;
    begin
      is_watch = (cause == `TDSR_CAUSE_DWATCH) || (cause == `TDSR_CAUSE_RWATCH);
    end
  endfunction

  // Bit 8 always shows the live issue mode; bit 5 and the upper bits read as zero.
  function [31:0] status_view;
    input [10:0] stored;
    input        live;
    begin
      status_view = {21'h000000, stored[10:9], live, stored[7:6], 1'b0, stored[4:0]};
    end
  endfunction

  // Reserved bits of the cause word read as zero.
  function [31:0] cause_view;
    input [1:0] bp;
    input [7:0] thread;
    input [2:0] code;
    begin
      cause_view = {14'h0000, bp, thread, 5'h00, code};
    end
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  reg [15:0] osc_tw_q;
  reg [15:0] osc_pc_q;
  reg [15:0] osc_pw_q;
  reg [10:0] cap_status_q;
  reg [31:0] cap_pc_q;
  reg [31:0] cap_sp_q;
  reg [7:0]  thread_sel_q;
  reg [4:0]  reg_sel_q;
  reg [2:0]  cause_code_q;
  reg [7:0]  cause_thread_q;
  reg [1:0]  cause_bp_q;
  reg [31:0] payload_q;
  reg [7:0]  hold_mask_q;
  reg [31:0] xchg_q [0:7];
  reg        wr_pend_q;
  reg [7:0]  wr_idx_q;

  wire       addr_ph   = hsel_i & hready_i & (htrans_i == `TDSR_HTRANS_NONSEQ);
  wire [7:0] addr_idx  = haddr_i[`TDSR_ADDR_IDX_HI:`TDSR_ADDR_IDX_LO];
  wire       xchg_wr   = wr_pend_q & in_xchg(wr_idx_q);
  wire       dbg_wr_ok = wr_pend_q & debug_mode_i;
  wire [1:0] bp_idx    = lowest_hit(dbg_entry_bp_hits_i);
  wire       bp_cause  = (dbg_entry_cause_i != `TDSR_CAUSE_HOST) &
                         (dbg_entry_cause_i != `TDSR_CAUSE_DEBUG_CALL_INSTR);

  // ************************************************************
  // Oscillator sampling
  // ************************************************************

  // Counts are sampled with no reset, so a system reset leaves them alone.
  // no reset
  always @(posedge clk_sys_i) begin
    osc_tw_q <= tile_wire_osc_count_i;
    osc_pc_q <= periph_cell_osc_count_i;
    osc_pw_q <= periph_wire_osc_count_i;
  end

  // ************************************************************
  // Bus phase tracking
  // ************************************************************
  // The bank never stalls and never errors, so ready and response stay constant.
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wr_pend_q   <= 1'b0;
      wr_idx_q    <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_q   <= addr_ph & hwrite_i & (hsize_i == `TDSR_HSIZE_WORD);
      wr_idx_q    <= addr_idx;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // ************************************************************
  // Debug state registers
  // ************************************************************

  // Hardware capture on debug entry wins over a bus write in the same cycle.
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cap_status_q   <= 11'h000;
      cap_pc_q       <= `TDSR_ZERO32;
      cap_sp_q       <= `TDSR_ZERO32;
      thread_sel_q   <= 8'h00;
      reg_sel_q      <= 5'h00;
      cause_code_q   <= 3'h0;
      cause_thread_q <= 8'h00;
      cause_bp_q     <= 2'h0;
      payload_q      <= `TDSR_ZERO32;
      hold_mask_q    <= 8'h00;
    end else begin
      if (dbg_entry_i) begin
        cap_status_q <= saved_status_register_i;
        cap_pc_q     <= saved_program_counter_i;
        cap_sp_q     <= saved_stack_pointer_i;
        cause_code_q <= dbg_entry_cause_i;
        cause_bp_q   <= bp_cause ? bp_idx : 2'h0;
        cause_thread_q <= (dbg_entry_cause_i == `TDSR_CAUSE_HOST) ?
                          8'h00 : dbg_entry_thread_i;
        if (is_watch(dbg_entry_cause_i)) begin
          payload_q <= dbg_entry_payload_i;
        end
      end else if (dbg_wr_ok) begin
        case (wr_idx_q)
          `TDSR_IDX_CAP_STATUS: begin
            cap_status_q <= (hwdata_i[`TDSR_STATUS_W-1:0] & `TDSR_STATUS_DRW_MASK) |
                            (cap_status_q & ~`TDSR_STATUS_DRW_MASK);
          end
          `TDSR_IDX_CAP_PC: begin
            cap_pc_q <= hwdata_i;
          end
          `TDSR_IDX_CAP_SP: begin
            cap_sp_q <= hwdata_i;
          end
          `TDSR_IDX_CAUSE: begin
            cause_code_q   <= hwdata_i[`TDSR_CAUSE_CODE_W-1:0];
            cause_thread_q <= hwdata_i[`TDSR_CAUSE_THREAD_LSB +: `TDSR_THREAD_W];
            cause_bp_q     <= hwdata_i[`TDSR_CAUSE_BP_LSB +: `TDSR_BPIDX_W];
          end
          `TDSR_IDX_PAYLOAD: begin
            payload_q <= hwdata_i;
          end
          default: begin
            cap_pc_q <= cap_pc_q;
          end
        endcase
      end
      if (dbg_wr_ok) begin
        case (wr_idx_q)
          `TDSR_IDX_THREAD_SEL: begin
            thread_sel_q <= hwdata_i[7:0];
          end
          `TDSR_IDX_REG_SEL: begin
            reg_sel_q <= hwdata_i[4:0];
          end
          `TDSR_IDX_HOLD_MASK: begin
            hold_mask_q <= hwdata_i[7:0];
          end
          default: begin
            hold_mask_q <= hold_mask_q;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Exchange words
  // ************************************************************

  // The bus write takes priority over a simultaneous configuration write.
  // shared scratch
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      xchg_q[0] <= `TDSR_ZERO32;
      xchg_q[1] <= `TDSR_ZERO32;
      xchg_q[2] <= `TDSR_ZERO32;
      xchg_q[3] <= `TDSR_ZERO32;
      xchg_q[4] <= `TDSR_ZERO32;
      xchg_q[5] <= `TDSR_ZERO32;
      xchg_q[6] <= `TDSR_ZERO32;
      xchg_q[7] <= `TDSR_ZERO32;
      cfg_xchg_rdata_o <= `TDSR_ZERO32;
    end else begin
      if (xchg_wr & debug_mode_i) begin
        xchg_q[wr_idx_q[2:0]] <= hwdata_i;
      end else if (cfg_xchg_we_i) begin
        xchg_q[cfg_xchg_idx_i] <= cfg_xchg_wdata_i;
      end
      cfg_xchg_rdata_o <= xchg_q[cfg_xchg_idx_i];
    end
  end

  // ************************************************************
  // Read mux and operand outputs
  // ************************************************************
  reg [31:0] rd_d;
  always @* begin
    rd_d = `TDSR_ZERO32;
    case (addr_idx)
      `TDSR_IDX_TILE_WIRE_OSC: rd_d = {16'h0000, osc_tw_q};
      `TDSR_IDX_PCELL_OSC:     rd_d = {16'h0000, osc_pc_q};
      `TDSR_IDX_PWIRE_OSC:     rd_d = {16'h0000, osc_pw_q};
      `TDSR_IDX_MEM_SIZE:      rd_d = `TDSR_MEM_SIZE_BYTES & `TDSR_MEM_SIZE_MASK;
      `TDSR_IDX_CAP_STATUS:    rd_d = status_view(cap_status_q, issue_mode_bit_i);
      `TDSR_IDX_CAP_PC:        rd_d = cap_pc_q;
      `TDSR_IDX_CAP_SP:        rd_d = cap_sp_q;
      `TDSR_IDX_THREAD_SEL:    rd_d = {24'h000000, thread_sel_q};
      `TDSR_IDX_REG_SEL:       rd_d = {27'h0000000, reg_sel_q};
      `TDSR_IDX_CAUSE:         rd_d = cause_view(cause_bp_q, cause_thread_q, cause_code_q);
      `TDSR_IDX_PAYLOAD:       rd_d = payload_q;
      `TDSR_IDX_HOLD_MASK:     rd_d = {24'h000000, hold_mask_q};
      default: begin
        if (in_xchg(addr_idx)) begin
          rd_d = xchg_q[addr_idx[2:0]];
        end
      end
    endcase
  end

  // Read data is latched at the address phase so it stands through the data phase.
  // Trade-off: a read issued right behind a write to the same word returns the old
  // value, because that write only lands at the end of the read's address phase.
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      hrdata_o              <= `TDSR_ZERO32;
      state_read_thread_o   <= 8'h00;
      state_read_register_o <= 5'h00;
      thread_hold_mask_o    <= 8'h00;
    end else begin
      if (addr_ph & ~hwrite_i) begin
        hrdata_o <= rd_d;
      end
      state_read_thread_o   <= thread_sel_q;
      state_read_register_o <= reg_sel_q;
      thread_hold_mask_o    <= hold_mask_q;
    end
  end

endmodule

// ### sim/tb_top.sv
// Self-checking bench for the tile debug state register bank.
`include "tdsr_consts.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, hsel, hwrite, dm, ent, iss, rd_dp;
  logic [31:0] haddr, hwdata, pay, pc, sp, w, g, exp_w, pe;
  logic [15:0] osc [3];
  logic [10:0] saved_status_register;
  logic [7:0]  thr;
  logic [3:0]  hits;
  logic [2:0]  hsize, cause, cs;
  logic [1:0]  htrans;
  wire  [31:0] hrdata, cwd, crd;
  wire  [7:0]  tsel, hmask;
  wire  [4:0]  rsel;
  wire  [2:0]  cix;
  wire         hready, cwe;
  int          failures = 0, n_tests = 0, cyc = 0;
  logic [31:0] exp_q [$];
  tdsr_regs tdsr_regs_inst (.clk_sys_i(clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
    .tile_wire_osc_count_i(osc[0]), .periph_cell_osc_count_i(osc[1]),
    .periph_wire_osc_count_i(osc[2]), .debug_mode_i(dm), .dbg_entry_i(ent),
    .dbg_entry_cause_i(cause), .dbg_entry_thread_i(thr), .dbg_entry_bp_hits_i(hits),
    .dbg_entry_payload_i(pay), .saved_status_register_i(saved_status_register), .saved_program_counter_i(pc),
    .saved_stack_pointer_i(sp), .issue_mode_bit_i(iss), .cfg_xchg_we_i(cwe),
    .cfg_xchg_idx_i(cix), .cfg_xchg_wdata_i(cwd), .cfg_xchg_rdata_o(crd),
    .state_read_thread_o(tsel), .state_read_register_o(rsel), .thread_hold_mask_o(hmask));
  tdsr_host_model tdsr_host_model_inst (.clk_sys_i(clk), .we_o(cwe), .idx_o(cix),
    .wdata_o(cwd), .rdata_i(crd));
  always #4 clk = ~clk;
  function automatic logic [1:0] lo(input logic [3:0] h);
    lo = 2'h0;
    for (int i = 3; i >= 0; i--) if (h[i]) lo = 2'(i);
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One single AHB-Lite transfer; a read notes its expected data first.
  task automatic bus(input logic wr, input logic [7:0] ix, input logic [31:0] d);
    if (!wr) exp_q.push_back(d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= `TDSR_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= `TDSR_HSIZE_WORD;
    haddr <= {22'h0, ix, 2'b00};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    rd_dp <= !wr;
    do @(posedge clk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  always @(posedge clk) if (rd_dp && hready === 1'b1) begin
    exp_w = exp_q.pop_front();
    `CHK("hrdata", exp_w, hrdata)
  end
  // The ceiling is about twenty times the length of the full sequence.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    {clk, nrst, hsel, hwrite, dm, ent, rd_dp} = '0;
    {haddr, hwdata, pay, pc, sp, pe, saved_status_register, thr, hits, hsize, cause, htrans} = '0;
    void'($urandom(32'h0A8F));
    foreach (osc[i]) osc[i] = 16'($urandom);
    iss = 1'($urandom);
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    dm <= 1'b1;
    bus(1, `TDSR_IDX_MEM_SIZE, 32'hFFFFFFFF);
    bus(0, `TDSR_IDX_MEM_SIZE, `TDSR_MEM_SIZE_BYTES);
    bus(1, `TDSR_IDX_TILE_WIRE_OSC, 32'h00000000);
    bus(0, 8'h0B, 32'h00000000);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 3; i++) bus(0, 8'(8'h08 + i), {16'h0, osc[i]});
    bus(0, `TDSR_IDX_CAUSE, 32'h00000000);
    `CHK("hold after reset", 8'h00, hmask)
    $display("test read-only done");
    for (int c = 1; c <= 6; c++) begin
      cs = (c == 6) ? `TDSR_CAUSE_IBREAK : 3'(c);
      @(posedge clk);
      {pc, sp, pay} <= {$urandom, $urandom, $urandom};
      saved_status_register <= 11'($urandom);
      thr <= 8'($urandom);
      hits <= 4'($urandom) | 4'h8;
      cause <= cs;
      ent <= 1'b1;
      @(posedge clk);
      ent <= 1'b0;
      pe = (cs > 3'h3) ? pay : pe;
      bus(0, `TDSR_IDX_CAP_STATUS, {21'h0, saved_status_register[10:9], iss, saved_status_register[7:6], 1'b0, saved_status_register[4:0]});
      bus(0, `TDSR_IDX_CAP_PC, pc);
      bus(0, `TDSR_IDX_CAP_SP, sp);
      bus(0, `TDSR_IDX_CAUSE, {14'h0, cs > 3'h2 ? lo(hits) : 2'h0,
        cs == 3'h1 ? 8'h0 : thr, 5'h0, cs});
      if (c > 3) bus(0, `TDSR_IDX_PAYLOAD, pe);
    end
    $display("test debug entry done");
    dm <= 1'b0;
    w = $urandom;
    bus(1, `TDSR_IDX_HOLD_MASK, 32'hFFFFFFFF);
    dm <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("hold refused", 8'h00, hmask)
    bus(1, `TDSR_IDX_HOLD_MASK, w);
    bus(1, `TDSR_IDX_THREAD_SEL, w >> 8);
    bus(1, `TDSR_IDX_REG_SEL, w);
    dm <= 1'b0;
    bus(1, `TDSR_IDX_THREAD_SEL, ~w);
    dm <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("hold mask", w[7:0], hmask)
    `CHK("thread select", w[15:8], tsel)
    `CHK("register select", w[4:0], rsel)
    bus(1, `TDSR_IDX_CAP_STATUS, w);
    bus(0, `TDSR_IDX_CAP_STATUS, (w & 32'h000006DF) | {23'h0, iss, 8'h00});
    bus(1, `TDSR_IDX_CAP_PC, w);
    bus(0, `TDSR_IDX_CAP_PC, w);
    $display("test debug writes done");
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      bus(1, 8'(`TDSR_IDX_XCHG_BASE + i), w);
      tdsr_host_model_inst.peek(3'(i), g);
      `CHK("exchange via config", w, g)
      tdsr_host_model_inst.poke(3'(i), ~w);
      bus(0, 8'(`TDSR_IDX_XCHG_BASE + i), ~w);
    end
    $display("test exchange words done");
    stop_test();
  end
endmodule
bind tdsr_regs tdsr_props tdsr_props_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .debug_mode_i(debug_mode_i),
  .issue_mode_bit_i(issue_mode_bit_i), .thread_hold_mask_o(thread_hold_mask_o),
  .state_read_register_o(state_read_register_o));

// ### sim/tdsr_host_model.sv
// Behavioural external debugger reaching the exchange words through config space.
module tdsr_host_model (
  // Clock
  input  wire         clk_sys_i,
  // Config-space exchange port
  output logic        we_o,
  output logic [2:0]  idx_o,
  output logic [31:0] wdata_o,
  input  wire  [31:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    we_o = 1'b0;
    idx_o = 3'h0;
    wdata_o = 32'h00000000;
  end
  task automatic poke(input logic [2:0] i, input logic [31:0] d);
    @(posedge clk_sys_i);
    we_o <= 1'b1;
    idx_o <= i;
    wdata_o <= d;
    @(posedge clk_sys_i);
    we_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // debugger reads one word, answered one cycle after the index
  task automatic peek(input logic [2:0] i, output logic [31:0] d);
    @(posedge clk_sys_i);
    idx_o <= i;
    repeat (2) @(posedge clk_sys_i);
    d = rdata_i;
  endtask
endmodule

// ### sim/tdsr_props.sv
// Port checker for the tile debug state register bank.
`include "tdsr_consts.vh"
module tdsr_props (
  // Clock and reset
  input wire        clk_sys_i,
  input wire        nrst_i,
  // Bus
  input wire        hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire [2:0]  hsize_i,
  input wire [31:0] hwdata_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  // Core side
  input wire        debug_mode_i,
  input wire        issue_mode_bit_i,
  input wire [7:0]  thread_hold_mask_o,
  input wire [4:0]  state_read_register_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire       ap = hsel_i && hready_i && htrans_i == `TDSR_HTRANS_NONSEQ;
  wire       rd = ap && !hwrite_i;
  wire [7:0] ix = haddr_i[9:2];
  reg        wr_q;
  reg  [7:0] wix_q;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // Data-phase view of word writes, since only those may change a register.
  always @(posedge clk_sys_i) begin
    wr_q  <= ap && hwrite_i && hsize_i == `TDSR_HSIZE_WORD;
    wix_q <= ix;
  end
  a_ready_high: assert property (hreadyout_o) else $error("ready low");
  a_resp_okay: assert property (!hresp_o) else $error("error response");
  a_rdata_holds: assert property (!rd |=> $stable(hrdata_o)) else $error("read data moved");
  a_osc_upper: assert property (rd && ix inside {8'h08, 8'h09, 8'h0A}
    |=> hrdata_o[31:16] == 16'h0000) else $error("osc upper bits set");
  a_mem_size: assert property (rd && ix == `TDSR_IDX_MEM_SIZE
    |=> hrdata_o == `TDSR_MEM_SIZE_BYTES) else $error("memory size wrong");
  a_status_fixed: assert property (rd && ix == `TDSR_IDX_CAP_STATUS
    |=> hrdata_o[31:11] == 21'h0 && !hrdata_o[5] && hrdata_o[8] == $past(issue_mode_bit_i))
    else $error("status fixed bits wrong");
  a_cause_fields: assert property (rd && ix == `TDSR_IDX_CAUSE
    |=> (hrdata_o & ~`TDSR_CAUSE_MASK) == 32'h0 && hrdata_o[2:0] <= 3'h5)
    else $error("cause reserved bits set");
  a_hold_follow: assert property (wr_q && debug_mode_i && wix_q == `TDSR_IDX_HOLD_MASK
    |-> ##2 thread_hold_mask_o == $past(hwdata_i[7:0], 2)) else $error("hold mask not loaded");
  a_hold_refused: assert property (wr_q && !debug_mode_i && wix_q == `TDSR_IDX_HOLD_MASK
    |-> ##2 $stable(thread_hold_mask_o)) else $error("write taken outside debug mode");
  a_regsel_follow: assert property (wr_q && debug_mode_i && wix_q == `TDSR_IDX_REG_SEL
    |-> ##2 state_read_register_o == $past(hwdata_i[4:0], 2)) else $error("register select");
endmodule
